// [common/gch_pkg.sv]
// constants, opcodes and carrier structs of the remote command handler
// assumes a front end that decodes bus messages and parses program messages
package gch_pkg;

  localparam int unsigned CLK_HZ       = 20000000;
  // least quiet time the controller keeps after a clear, in ms
  localparam int unsigned CLR_QUIET_MS = 100;
  localparam int unsigned CLR_QUIET_CYC = CLK_HZ / 1000 * CLR_QUIET_MS;

  // response size limit in bytes
  localparam int unsigned RESP_LIMIT_B = 10240;
  localparam int unsigned RESP_CNT_W   = 14;

  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ARG_W  = 16;
  localparam logic [ARG_W-1:0] ARG_MAX = 16'h00ff;

  // standard event status bit positions
  localparam int unsigned ESR_OPC = 0;
  localparam int unsigned ESR_QYE = 2;
  localparam int unsigned ESR_DDE = 3;
  localparam int unsigned ESR_EXE = 4;
  localparam int unsigned ESR_CME = 5;

  // status byte bit positions
  localparam int unsigned STB_MAV = 4;
  localparam int unsigned STB_ESB = 5;
  localparam int unsigned STB_RQS = 6;

  localparam logic [BYTE_W-1:0] MASK_RST  = 8'h00;
  localparam logic [BYTE_W-1:0] OPC_REPLY = 8'h01;

  typedef enum logic [3:0] {
    OP_NONE, OP_CLS, OP_ESE, OP_ESE_Q, OP_ESR_Q, OP_OPC, OP_OPC_Q, OP_RST,
    OP_SRE, OP_SRE_Q, OP_STB_Q, OP_TRG, OP_WAI
  } gch_op_t;

  typedef struct packed {
    logic ren;   // remote enable line
    logic lstn;  // addressed to listen
    logic gtl;
    logic llo;
    logic dcl;
    logic sdc;
    logic get;
  } gch_bus_msg_t;

  typedef struct packed {
    logic             valid;
    gch_op_t          op;
    logic             trail;   // data followed a parameterless header
    logic             has_arg;
    logic [ARG_W-1:0] arg;
  } gch_cmd_t;

  typedef struct packed {
    logic              valid;
    logic [BYTE_W-1:0] data;
  } gch_resp_t;

endpackage

// [src/gch_esr.sv]
// standard event status register with its enable mask and summary bit
// assumes single cycle set pulses and clear strobes from the handler
`timescale 1ns/1ps
module gch_esr (
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  input  wire logic [gch_pkg::BYTE_W-1:0] set_bits,
  input  wire logic                      clr,
  input  wire logic                      mask_wr,
  input  wire logic [gch_pkg::BYTE_W-1:0] mask_wdata,
  output logic      [gch_pkg::BYTE_W-1:0] esr_q,
  output logic      [gch_pkg::BYTE_W-1:0] mask_q,
  output logic                           esb_q
);
  logic [gch_pkg::BYTE_W-1:0] esr_d;
  logic [gch_pkg::BYTE_W-1:0] mask_d;
  logic                      esb_d;

  always_comb begin
    // an event in the clearing cycle survives the clear
    esr_d  = clr ? set_bits : (esr_q | set_bits);
    mask_d = mask_wr ? mask_wdata : mask_q;
    esb_d  = |(esr_d & mask_d);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      esr_q  <= '0;
      mask_q <= gch_pkg::MASK_RST;
      esb_q  <= 1'b0;
    end else begin
      esr_q  <= esr_d;
      mask_q <= mask_d;
      esb_q  <= esb_d;
    end
  end
endmodule // gch_esr

// [src/gch_resp_guard.sv]
// counts response bytes of one message and flags an oversized one
// assumes the formatter marks the final byte of each response with last
`timescale 1ns/1ps
module gch_resp_guard (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic flush,
  input  wire logic beat,
  input  wire logic last,
  output logic      over_q,
  output logic      drop_q
);
  logic [gch_pkg::RESP_CNT_W-1:0] cnt_q;
  logic [gch_pkg::RESP_CNT_W-1:0] cnt_d;
  logic                          full_q;
  logic                          full_d;
  logic                          over_d;
  logic                          drop_d;

  localparam logic [gch_pkg::RESP_CNT_W-1:0] LIMIT =
    gch_pkg::RESP_CNT_W'(gch_pkg::RESP_LIMIT_B);

  always_comb begin
    cnt_d  = cnt_q;
    full_d = full_q;
    over_d = 1'b0;
    drop_d = beat && full_q;
    if (flush) begin
      cnt_d  = '0;
      full_d = 1'b0;
    end else if (beat) begin
      // the byte past the limit is refused and raises the error once
      over_d = full_q && (cnt_q == LIMIT);
      if (last) begin
        cnt_d  = '0;
        full_d = 1'b0;
      end else if (!full_q) begin
        cnt_d  = cnt_q + 1'b1;
        full_d = (cnt_q + 1'b1) == LIMIT;
      end else begin
        cnt_d  = '1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      full_q <= 1'b0;
      over_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      full_q <= full_d;
      over_q <= over_d;
      drop_q <= drop_d;
    end
  end
endmodule // gch_resp_guard

// [src/gch_top.sv]
// remote command handler: bus messages, common commands, status reporting
// assumes decoded bus messages and parsed commands arrive as one-cycle strobes
//
// Summary of operation
// - go-to-local drops remote state
// - local lockout ignores every front-panel key
// - selected device clear flushes input and output
// - group trigger samples once when external
// - enable mask command stores value 0..255
// - service request mask stored and read back
// - clear status zeroes event registers
// - trailing data after bare header is error
// - response beyond 10 kB is query error
// - compensation in progress makes execution error for comp_locked commands
// - software trigger with internal source errors
// - out-of-range argument makes execution error
// - software trigger samples once
// - operation complete sets event after idle
// - completion query answers only after idle
// - enabled event bits feed summary status
`timescale 1ns/1ps
module gch_top (
  input  wire logic                       sys_clk,
  input  wire logic                       rstn,
  input  wire gch_pkg::gch_bus_msg_t      bus_msg,
  input  wire gch_pkg::gch_cmd_t          cmd,
  input  wire logic                       key_press,
  input  wire logic                       key_is_local,
  input  wire logic                       trig_ext,
  input  wire logic                       comp_busy,
  input  wire logic                       ops_busy,
  input  wire logic                       dev_err,
  input  wire logic                       mav,
  input  wire logic                       resp_beat,
  input  wire logic                       resp_last,
  output logic                            remote_q,
  output logic                            lockout_q,
  output logic                            key_accept_q,
  output logic                            flush_q,
  output logic                            sample_q,
  output logic                            dev_reset_q,
  output logic                            cmd_ready_q,
  output gch_pkg::gch_resp_t              resp_q,
  output logic                            resp_drop_q,
  output logic                            srq_q,
  output logic [gch_pkg::BYTE_W-1:0]      stb_q
);

  // ****************************************************************
  // command classification
  // ****************************************************************

  // commands that take no parameter
  function automatic logic is_bare(input gch_pkg::gch_op_t op);
    return !(op inside {gch_pkg::OP_ESE, gch_pkg::OP_SRE, gch_pkg::OP_NONE});
  endfunction

  // commands refused during open, short or load compensation
  function automatic logic comp_locked(input gch_pkg::gch_op_t op);
    return op inside {gch_pkg::OP_CLS, gch_pkg::OP_ESE, gch_pkg::OP_ESE_Q,
                      gch_pkg::OP_RST, gch_pkg::OP_SRE, gch_pkg::OP_SRE_Q,
                      gch_pkg::OP_STB_Q, gch_pkg::OP_TRG};
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************

  typedef enum logic [1:0] {
    ST_IDLE, ST_OPC_WAIT, ST_OPCQ_WAIT, ST_WAI_WAIT
  } gch_state_t;

  gch_state_t                  state_q;
  gch_state_t                  state_d;
  logic                        remote_d;
  logic                        lockout_d;
  logic                        key_accept_d;
  logic                        flush_d;
  logic                        sample_d;
  logic                        dev_reset_d;
  logic                        cmd_ready_d;
  gch_pkg::gch_resp_t          resp_d;
  logic                        srq_d;
  logic [gch_pkg::BYTE_W-1:0]  stb_d;
  logic [gch_pkg::BYTE_W-1:0]  sre_q;
  logic [gch_pkg::BYTE_W-1:0]  sre_d;

  logic                        take;
  logic                        err_cme;
  logic                        err_exe;
  logic                        run;
  logic                        esr_clr;
  logic                        ese_wr;
  logic [gch_pkg::BYTE_W-1:0]  esr_set;
  logic [gch_pkg::BYTE_W-1:0]  esr_val;
  logic [gch_pkg::BYTE_W-1:0]  ese_val;
  logic                        esb;
  logic                        qye;
  logic                        clear_msg;

  assign clear_msg = bus_msg.dcl || bus_msg.sdc;
  // commands are only taken while no wait is pending
  assign take = cmd.valid && (state_q == ST_IDLE);

  // ****************************************************************
  // error screening
  // ****************************************************************

  always_comb begin
    err_cme = take && is_bare(cmd.op) && cmd.trail;
    err_exe = 1'b0;
    if (take && !err_cme) begin
      if (comp_busy && comp_locked(cmd.op)) begin
        err_exe = 1'b1;
      end else if (cmd.op == gch_pkg::OP_TRG && !trig_ext) begin
        err_exe = 1'b1;
      end else if ((cmd.op inside {gch_pkg::OP_ESE, gch_pkg::OP_SRE}) &&
                   (!cmd.has_arg || cmd.arg > gch_pkg::ARG_MAX)) begin
        err_exe = 1'b1;
      end
    end
    run = take && !err_cme && !err_exe;
  end

  // ****************************************************************
  // local / remote and front panel
  // ****************************************************************

  always_comb begin
    remote_d     = remote_q;
    lockout_d    = lockout_q;
    key_accept_d = 1'b0;
    if (!bus_msg.ren) begin
      remote_d  = 1'b0;
      lockout_d = 1'b0;
    end else begin
      if (bus_msg.llo) begin
        lockout_d = 1'b1;
      end
      if (bus_msg.gtl) begin
        remote_d = 1'b0;
      end else if (bus_msg.lstn) begin
        remote_d = 1'b1;
      end
    end
    if (key_press && !lockout_q) begin
      if (!remote_q) begin
        key_accept_d = 1'b1;
      end else if (key_is_local) begin
        remote_d = 1'b0;
      end
    end
  end

  // ****************************************************************
  // command execution and completion tracking
  // ****************************************************************

  always_comb begin
    state_d     = state_q;
    flush_d     = clear_msg;
    sample_d    = 1'b0;
    dev_reset_d = 1'b0;
    sre_d       = sre_q;
    esr_clr     = 1'b0;
    ese_wr      = 1'b0;
    resp_d      = '0;
    esr_set     = '0;
    esr_set[gch_pkg::ESR_CME] = err_cme;
    esr_set[gch_pkg::ESR_EXE] = err_exe;
    esr_set[gch_pkg::ESR_QYE] = qye;
    esr_set[gch_pkg::ESR_DDE] = dev_err;
    if (bus_msg.get && trig_ext) begin
      sample_d = 1'b1;
    end
    if (run) begin
      unique case (cmd.op)
        gch_pkg::OP_CLS: begin
          esr_clr = 1'b1;
        end
        gch_pkg::OP_ESE: begin
          ese_wr = 1'b1;
        end
        gch_pkg::OP_SRE: begin
          sre_d = cmd.arg[gch_pkg::BYTE_W-1:0];
        end
        gch_pkg::OP_ESE_Q: begin
          resp_d = '{valid: 1'b1, data: ese_val};
        end
        gch_pkg::OP_SRE_Q: begin
          resp_d = '{valid: 1'b1, data: sre_q};
        end
        gch_pkg::OP_ESR_Q: begin
          // reading the event register empties it
          resp_d  = '{valid: 1'b1, data: esr_val};
          esr_clr = 1'b1;
        end
        gch_pkg::OP_STB_Q: begin
          resp_d = '{valid: 1'b1, data: stb_q};
        end
        gch_pkg::OP_TRG: begin
          sample_d = 1'b1;
        end
        gch_pkg::OP_RST: begin
          dev_reset_d = 1'b1;
        end
        gch_pkg::OP_OPC: begin
          state_d = ST_OPC_WAIT;
        end
        gch_pkg::OP_OPC_Q: begin
          state_d = ST_OPCQ_WAIT;
        end
        gch_pkg::OP_WAI: begin
          state_d = ST_WAI_WAIT;
        end
        gch_pkg::OP_NONE: begin
          state_d = state_q;
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
    // state_q is ST_IDLE whenever run is set, so waits never overlap
    unique case (state_q)
      ST_IDLE: begin
        state_d = state_d;
      end
      ST_OPC_WAIT: begin
        if (!ops_busy) begin
          esr_set[gch_pkg::ESR_OPC] = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_OPCQ_WAIT: begin
        if (!ops_busy) begin
          resp_d  = '{valid: 1'b1, data: gch_pkg::OPC_REPLY};
          state_d = ST_IDLE;
        end
      end
      ST_WAI_WAIT: begin
        if (!ops_busy) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    // a clear abandons any pending completion wait; the controller is
    // expected to stay quiet for a while after it
    if (clear_msg) begin
      state_d = ST_IDLE;
      resp_d  = '0;
    end
    cmd_ready_d = (state_d == ST_IDLE);
  end

  // ****************************************************************
  // status byte and service request
  // ****************************************************************

  always_comb begin
    stb_d = '0;
    stb_d[gch_pkg::STB_MAV] = mav;
    stb_d[gch_pkg::STB_ESB] = esb;
    srq_d = |(stb_d & sre_q);
    stb_d[gch_pkg::STB_RQS] = srq_d;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q      <= ST_IDLE;
      remote_q     <= 1'b0;
      lockout_q    <= 1'b0;
      key_accept_q <= 1'b0;
      flush_q      <= 1'b0;
      sample_q     <= 1'b0;
      dev_reset_q  <= 1'b0;
      cmd_ready_q  <= 1'b1;
      resp_q       <= '0;
      sre_q        <= gch_pkg::MASK_RST;
      srq_q        <= 1'b0;
      stb_q        <= '0;
    end else begin
      state_q      <= state_d;
      remote_q     <= remote_d;
      lockout_q    <= lockout_d;
      key_accept_q <= key_accept_d;
      flush_q      <= flush_d;
      sample_q     <= sample_d;
      dev_reset_q  <= dev_reset_d;
      cmd_ready_q  <= cmd_ready_d;
      resp_q       <= resp_d;
      sre_q        <= sre_d;
      srq_q        <= srq_d;
      stb_q        <= stb_d;
    end
  end

  // ****************************************************************
  // submodules
  // ****************************************************************

  gch_esr u_esr (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .set_bits   (esr_set),
    .clr        (esr_clr),
    .mask_wr    (ese_wr),
    .mask_wdata (cmd.arg[gch_pkg::BYTE_W-1:0]),
    .esr_q      (esr_val),
    .mask_q     (ese_val),
    .esb_q      (esb)
  );

  gch_resp_guard u_guard (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .flush   (clear_msg),
    .beat    (resp_beat),
    .last    (resp_last),
    .over_q  (qye),
    .drop_q  (resp_drop_q)
  );

endmodule // gch_top

// [tb/gch_top_checker.sv]
// port assertions for the remote command handler
// assumes one clock domain and the async active-low reset of gch_top
`timescale 1ns/1ps
module gch_top_checker (
  input wire logic                  sys_clk,
  input wire logic                  rstn,
  input wire gch_pkg::gch_bus_msg_t bus_msg,
  input wire gch_pkg::gch_cmd_t     cmd,
  input wire logic                  key_press,
  input wire logic                  trig_ext,
  input wire logic                  comp_busy,
  input wire logic                  ops_busy,
  input wire logic                  remote_q,
  input wire logic                  lockout_q,
  input wire logic                  key_accept_q,
  input wire logic                  flush_q,
  input wire logic                  sample_q,
  input wire logic                  cmd_ready_q,
  input wire gch_pkg::gch_resp_t    resp_q,
  input wire logic                  resp_drop_q,
  input wire logic                  srq_q
);
  // ********************
  // properties
  // ********************
  logic take;
  assign take = cmd.valid && cmd_ready_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  gtl_local_a: assert property (bus_msg.gtl && !bus_msg.lstn |=> !remote_q)
    else $error("remote kept after go to local");
  ren_drop_a: assert property (!bus_msg.ren |=> !remote_q && !lockout_q)
    else $error("remote kept without remote enable");
  llo_set_a: assert property (bus_msg.llo && bus_msg.ren |=> lockout_q)
    else $error("lockout not taken");
  key_ignored_a: assert property (lockout_q && key_press && !bus_msg.gtl
    && bus_msg.ren |=> !key_accept_q && (remote_q || !$past(remote_q)))
    else $error("key acted in lockout");
  clear_flush_a: assert property (bus_msg.dcl || bus_msg.sdc |=> flush_q)
    else $error("no flush after clear");
  get_sample_a: assert property (bus_msg.get && trig_ext |=> sample_q)
    else $error("no sample after group trigger");
  trg_fire_a: assert property (take && cmd.op == gch_pkg::OP_TRG
    && !cmd.trail && trig_ext && !comp_busy |=> sample_q)
    else $error("no sample after software trigger");
  trg_block_a: assert property (take && cmd.op == gch_pkg::OP_TRG
    && (cmd.trail || !trig_ext || comp_busy) && !bus_msg.get |=> !sample_q)
    else $error("errored trigger sampled");
  sre_answer_a: assert property (take && cmd.op == gch_pkg::OP_SRE_Q && !cmd.trail
    && !comp_busy |=> resp_q.valid) else $error("mask query unanswered");
  opc_hold_a: assert property (take && cmd.op == gch_pkg::OP_OPC_Q ##1 ops_busy
    |=> !resp_q.valid) else $error("completion answered while busy");
  opc_reply_a: assert property (take && cmd.op == gch_pkg::OP_OPC_Q && !cmd.trail
    ##1 !ops_busy |=> resp_q.valid && resp_q.data == gch_pkg::OPC_REPLY)
    else $error("completion reply missing");

  cover property (take && cmd.op == gch_pkg::OP_OPC_Q ##1 ops_busy);
  cover property (resp_drop_q);
  cover property (srq_q);
  cover property (lockout_q && key_press);
endmodule // gch_top_checker

bind gch_top gch_top_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .bus_msg(bus_msg),
  .cmd(cmd), .key_press(key_press), .trig_ext(trig_ext), .comp_busy(comp_busy),
  .ops_busy(ops_busy), .remote_q(remote_q), .lockout_q(lockout_q),
  .key_accept_q(key_accept_q), .flush_q(flush_q), .sample_q(sample_q),
  .cmd_ready_q(cmd_ready_q), .resp_q(resp_q), .resp_drop_q(resp_drop_q), .srq_q(srq_q));

// [tb/gch_ctl_model.sv]
// stand-in for the bus controller: bus messages and program commands
// assumes the handler takes a command on an edge where cmd_ready_q is high
`timescale 1ns/1ps
module gch_ctl_model #(
  parameter int QUIET_CYC = 40
) (
  input  wire logic             sys_clk,
  input  wire logic             cmd_ready_q,
  output gch_pkg::gch_bus_msg_t bus_msg,
  output gch_pkg::gch_cmd_t     cmd,
  output logic                  hung
);
  initial begin
    bus_msg = '0;
    cmd = '0;
    hung = 1'b0;
  end
  task automatic levels(input logic ren, input logic lstn);
    @(posedge sys_clk);
    #2;
    bus_msg.ren = ren;
    bus_msg.lstn = lstn;
  endtask
  // sel: 0 go to local, 1 lockout, 2 clear, 3 selected clear, 4 trigger
  task automatic pulse(input int sel);
    @(posedge sys_clk);
    #2;
    bus_msg[4-sel] = 1'b1;
    @(posedge sys_clk);
    #2;
    bus_msg[4-sel] = 1'b0;
    // queues are being emptied; stay quiet (shortened from the real 100 ms)
    if (sel == 2 || sel == 3) begin
      repeat (QUIET_CYC) @(posedge sys_clk);
      #2;
    end
  endtask
  task automatic send(input gch_pkg::gch_op_t op, input logic trail, input logic [15:0] arg);
    int n;
    n = 0;
    @(posedge sys_clk);
    #2;
    while (cmd_ready_q !== 1'b1) begin
      n++;
      if (n > 5000) hung = 1'b1;
      @(posedge sys_clk);
      #2;
    end
    cmd = '{1'b1, op, trail, op inside {gch_pkg::OP_ESE, gch_pkg::OP_SRE}, arg};
    @(posedge sys_clk);
    #2;
    // released fields flip so a stale value never looks like a command
    cmd = '{1'b0, op, ~trail, 1'b0, ~arg};
  endtask
endmodule // gch_ctl_model

// [tb/gch_top_tb_top.sv]
// self-checking bench for the remote command handler
// assumes the controller model drives bus messages and commands
`timescale 1ns/1ps
module gch_top_tb_top;
  logic sys_clk = 1'b0;
  logic rstn, key_press, key_is_local, trig_ext, comp_busy, ops_busy, dev_err, mav;
  logic resp_beat, resp_last, remote_q, lockout_q, key_accept_q, flush_q, sample_q;
  logic dev_reset_q, cmd_ready_q, resp_drop_q, srq_q, ctl_hung;
  logic [7:0]            stb_q, v;
  gch_pkg::gch_bus_msg_t bus_msg;
  gch_pkg::gch_cmd_t     cmd;
  gch_pkg::gch_resp_t    resp_q;
  logic [7:0]            exp_q[$];
  int fails = 0, total_checks = 0, samp_cnt = 0, flush_cnt = 0, drop_cnt = 0, resp_cnt = 0;
  int acc_cnt = 0, rst_cnt = 0;
  int seed = 46391, s;

  always #25 sys_clk = ~sys_clk;

  gch_top uut (.sys_clk(sys_clk), .rstn(rstn), .bus_msg(bus_msg), .cmd(cmd),
    .key_press(key_press), .key_is_local(key_is_local), .trig_ext(trig_ext),
    .comp_busy(comp_busy), .ops_busy(ops_busy), .dev_err(dev_err), .mav(mav),
    .resp_beat(resp_beat), .resp_last(resp_last), .remote_q(remote_q),
    .lockout_q(lockout_q), .key_accept_q(key_accept_q), .flush_q(flush_q),
    .sample_q(sample_q), .dev_reset_q(dev_reset_q), .cmd_ready_q(cmd_ready_q),
    .resp_q(resp_q), .resp_drop_q(resp_drop_q), .srq_q(srq_q), .stb_q(stb_q));
  gch_ctl_model ctl (.sys_clk(sys_clk), .cmd_ready_q(cmd_ready_q), .bus_msg(bus_msg),
    .cmd(cmd), .hung(ctl_hung));

  // ********************
  // checking and report
  // ********************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic query(input gch_pkg::gch_op_t op, input logic [7:0] exp);
    exp_q.push_back(exp);
    ctl.send(op, 1'b0, 16'h0000);
    tick(2);
  endtask
  task automatic key();
    key_press = 1'b1;
    key_is_local = 1'b1;
    tick(1);
    key_press = 1'b0;
    key_is_local = 1'b0;
    tick(2);
  endtask

  // responses are matched in order against what the driver noted
  always @(posedge sys_clk) begin
    samp_cnt += int'(sample_q === 1'b1);
    flush_cnt += int'(flush_q === 1'b1);
    drop_cnt += int'(resp_drop_q === 1'b1);
    acc_cnt += int'(key_accept_q === 1'b1);
    rst_cnt += int'(dev_reset_q === 1'b1);
    if (resp_q.valid === 1'b1) begin
      resp_cnt++;
      check(16'(exp_q.size() != 0), 16'h0001);
      if (exp_q.size() != 0) check(resp_q.data, exp_q.pop_front());
    end
  end
  always @(posedge ctl_hung) begin
    fails++;
    final_report();
  end

  // ********************
  // scenarios
  // ********************
  initial begin
    {rstn, key_press, key_is_local, trig_ext, comp_busy, ops_busy, dev_err, mav} = '0;
    {resp_beat, resp_last} = '0;
    repeat (4) @(posedge sys_clk);
    #2;
    rstn = 1'b1;
    check(cmd_ready_q, 1'b1);
    check(stb_q, 8'h00);
    ctl.levels(1'b1, 1'b1);
    ctl.levels(1'b1, 1'b0);
    check(remote_q, 1'b1);
    ctl.pulse(0);
    check(remote_q, 1'b0);
    s = acc_cnt;
    key();
    check(acc_cnt - s, 1);
    ctl.levels(1'b1, 1'b1);
    ctl.levels(1'b1, 1'b0);
    key();
    check(remote_q, 1'b0);
    ctl.pulse(1);
    check(lockout_q, 1'b1);
    ctl.levels(1'b1, 1'b1);
    ctl.levels(1'b1, 1'b0);
    key();
    check(remote_q, 1'b1);
    check(acc_cnt - s, 1);
    ctl.levels(1'b0, 1'b0);
    tick(1);
    check(lockout_q, 1'b0);
    for (int i = 2; i < 4; i++) begin
      s = flush_cnt;
      ctl.pulse(i);
      check(flush_cnt - s, 1);
    end
    trig_ext = 1'b1;
    s = samp_cnt;
    ctl.pulse(4);
    tick(3);
    check(samp_cnt - s, 1);
    trig_ext = 1'b0;
    ctl.pulse(4);
    tick(3);
    check(samp_cnt - s, 1);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      ctl.send(gch_pkg::OP_SRE, 1'b0, {8'h00, v});
      query(gch_pkg::OP_SRE_Q, v);
      ctl.send(gch_pkg::OP_ESE, 1'b0, {8'h00, ~v});
      query(gch_pkg::OP_ESE_Q, ~v);
    end
    ctl.send(gch_pkg::OP_SRE, 1'b0, 16'h0100);
    query(gch_pkg::OP_SRE_Q, v);
    query(gch_pkg::OP_ESR_Q, 8'h10);
    trig_ext = 1'b1;
    s = samp_cnt;
    ctl.send(gch_pkg::OP_TRG, 1'b1, 16'h0000);
    ctl.send(gch_pkg::OP_STB_Q, 1'b1, 16'h0000);
    query(gch_pkg::OP_ESR_Q, 8'h20);
    ctl.send(gch_pkg::OP_TRG, 1'b0, 16'h0000);
    tick(3);
    check(samp_cnt - s, 1);
    comp_busy = 1'b1;
    ctl.send(gch_pkg::OP_TRG, 1'b0, 16'h0000);
    comp_busy = 1'b0;
    query(gch_pkg::OP_ESR_Q, 8'h10);
    trig_ext = 1'b0;
    ctl.send(gch_pkg::OP_TRG, 1'b0, 16'h0000);
    query(gch_pkg::OP_ESR_Q, 8'h10);
    check(samp_cnt - s, 1);
    // a refused reset must not pulse, the following one must
    s = rst_cnt;
    comp_busy = 1'b1;
    ctl.send(gch_pkg::OP_RST, 1'b0, 16'h0000);
    comp_busy = 1'b0;
    ctl.send(gch_pkg::OP_RST, 1'b0, 16'h0000);
    query(gch_pkg::OP_ESR_Q, 8'h10);
    check(rst_cnt - s, 1);
    dev_err = 1'b1;
    tick(1);
    dev_err = 1'b0;
    ctl.send(gch_pkg::OP_CLS, 1'b0, 16'h0000);
    query(gch_pkg::OP_ESR_Q, 8'h00);
    ctl.send(gch_pkg::OP_ESE, 1'b0, 16'h0001);
    ctl.send(gch_pkg::OP_SRE, 1'b0, 16'h0020);
    ops_busy = 1'b1;
    ctl.send(gch_pkg::OP_OPC, 1'b0, 16'h0000);
    tick(5);
    check(srq_q, 1'b0);
    ops_busy = 1'b0;
    tick(4);
    check(srq_q, 1'b1);
    check(stb_q[gch_pkg::STB_ESB], 1'b1);
    ctl.send(gch_pkg::OP_CLS, 1'b0, 16'h0000);
    tick(4);
    check(srq_q, 1'b0);
    ops_busy = 1'b1;
    ctl.send(gch_pkg::OP_WAI, 1'b0, 16'h0000);
    tick(2);
    check(cmd_ready_q, 1'b0);
    ops_busy = 1'b0;
    tick(2);
    check(cmd_ready_q, 1'b1);
    for (int b = 1; b >= 0; b--) begin
      ops_busy = b[0];
      s = resp_cnt;
      exp_q.push_back(gch_pkg::OPC_REPLY);
      ctl.send(gch_pkg::OP_OPC_Q, 1'b0, 16'h0000);
      tick(6);
      check(resp_cnt - s, 1 - b);
      ops_busy = 1'b0;
      tick(4);
      check(resp_cnt - s, 1);
    end
    s = drop_cnt;
    resp_beat = 1'b1;
    tick(gch_pkg::RESP_LIMIT_B);
    resp_last = 1'b1;
    tick(1);
    {resp_beat, resp_last} = '0;
    tick(3);
    check(drop_cnt - s, 1);
    query(gch_pkg::OP_ESR_Q, 8'h04);
    mav = 1'b1;
    query(gch_pkg::OP_STB_Q, 8'h10);
    mav = 1'b0;
    tick(5);
    check(exp_q.size(), 0);
    final_report();
  end
endmodule // gch_top_tb_top
